//--- pkg/brc_consts.svh
/*
 * constants for the board reset configuration select block.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// ==========================================================
// boot sequencer codes
`define BRC_BOOT_RSVD     2'h0
`define BRC_BOOT_NORMAL   2'h1
`define BRC_BOOT_EXT      2'h2
`define BRC_BOOT_OFF      2'h3

// ==========================================================
// ddr pll ratio codes and multipliers
`define BRC_PLL_6         3'h2
`define BRC_PLL_8         3'h3
`define BRC_PLL_10        3'h4
`define BRC_RATIO_6       4'h6
`define BRC_RATIO_8       4'h8
`define BRC_RATIO_10      4'ha
`define BRC_RATIO_NONE    4'h0

// ==========================================================
// frequencies in mhz
`define BRC_F33           8'h21
`define BRC_F40           8'h28
`define BRC_F50           8'h32
`define BRC_F66           8'h42
`define BRC_F83           8'h53
`define BRC_F100          8'h64
`define BRC_F134          8'h86
`define BRC_F166          8'ha6
`define BRC_F125          8'h7d
`define BRC_F133          8'h85
`define BRC_F_NONE        8'h00
`define BRC_MEM_UNDEF     3'h7
`define BRC_KHZ_PER_MHZ   24'h0003e8

// ==========================================================
// timing
`define BRC_CLK_NS        4
`define BRC_SCLK_HALF_NS  20
`define BRC_SCLK_HALF_CYC ((`BRC_SCLK_HALF_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)
`define BRC_HOLD_NS       100
`define BRC_HOLD_CYC      ((`BRC_HOLD_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)
`define BRC_WORD_BITS     24

`endif

//--- pkg/brc_pkg.sv
/*
 * types for the board reset configuration select block.
 * assumes brc_consts.svh is on the include path.
 */
`default_nettype none

package brc_pkg;

    // ======================================================
    // selections from switches or registers
    typedef struct packed {
        logic [1:0] boot_seq;
        logic [2:0] ddr_pll;
        logic [2:0] sysclk_sel;
        logic [2:0] memory_clock_freq_sel;
        logic       ata_freq_strap;
    } brc_cfg_t;

    // processor configuration pin group
    typedef struct packed {
        logic [1:0] boot_seq;
        logic [2:0] ddr_pll;
    } brc_pins_t;

    typedef enum logic [2:0] {
        ST_HOLD     = 3'h0,
        ST_LOAD_SYS = 3'h1,
        ST_WAIT_SYS = 3'h2,
        ST_LOAD_MEM = 3'h3,
        ST_WAIT_MEM = 3'h4,
        ST_DRIVE    = 3'h5,
        ST_RUN      = 3'h6
    } brc_state_t;

endpackage

`default_nettype wire

//--- rtl/brc_synth_loader.sv
/*
 * serial word loader for the clock synthesizer: msb first, data changes
 * while the serial clock is low, a strobe pulse latches the word.
 * assumes a one-cycle start pulse only while busy_o is low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brc_consts.svh"

module brc_synth_loader #(
    parameter int WORD_BITS = `BRC_WORD_BITS,
    parameter int HALF_CYC  = `BRC_SCLK_HALF_CYC
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 start_i,
    input  wire logic [WORD_BITS-1:0] word_i,
    output logic                      busy_o,
    output logic                      done_o,
    output logic                      sclk_o,
    output logic                      data_o,
    output logic                      strobe_o
);

    // ======================================================
    // shifter
    logic [WORD_BITS-1:0] shift;
    logic [7:0]           bits_left;
    logic [7:0]           half_cnt;
    logic                 strobing;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shift     <= '0;
            bits_left <= 8'h00;
            half_cnt  <= 8'h00;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            sclk_o    <= 1'b0;
            data_o    <= 1'b0;
            strobe_o  <= 1'b0;
            strobing  <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (!busy_o)
            begin
                if (start_i)
                begin
                    busy_o    <= 1'b1;
                    data_o    <= word_i[WORD_BITS-1];
                    shift     <= {word_i[WORD_BITS-2:0], 1'b0};
                    bits_left <= 8'(WORD_BITS);
                    half_cnt  <= 8'(HALF_CYC - 1);
                end
            end
            else if (half_cnt != 8'h00)
            begin
                half_cnt <= half_cnt - 8'h01;
            end
            else if (strobing)
            begin
                // strobe has stood one half period: word taken
                strobe_o <= 1'b0;
                strobing <= 1'b0;
                busy_o   <= 1'b0;
                done_o   <= 1'b1;
            end
            else if (!sclk_o)
            begin
                sclk_o   <= 1'b1;
                half_cnt <= 8'(HALF_CYC - 1);
            end
            else
            begin
                sclk_o    <= 1'b0;
                half_cnt  <= 8'(HALF_CYC - 1);
                bits_left <= bits_left - 8'h01;
                if (bits_left == 8'h01)
                begin
                    strobe_o <= 1'b1;
                    strobing <= 1'b1;
                end
                else
                begin
                    data_o <= shift[WORD_BITS-1];
                    shift  <= {shift[WORD_BITS-2:0], 1'b0};
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- rtl/brc_config_select.sv
/*
 * board reset configuration select: picks switch or register settings,
 * drives processor configuration pins during system reset, loads the
 * clock synthesizer, then lets the processor out of reset.
 * assumes sys_reset_n_i and all selections are synchronous to clk_sys_i.
 */
// Operation
// R1 - boot code 01: sequencer on, normal two-wire addressing, rom needed
// R2 - boot code 10: sequencer on, extended addressing; code 00 reserved
// R3 - boot code 11 disables sequencer and is the default
// R4 - ddr pll 010 is 6:1, 011 is 8:1, 100 is 10:1; 000, 001 reserved
// R5 - system clock codes 000..011 give 33, 40, 50, 66 mhz
// R6 - system clock codes 100..111 give 83, 100, 134, 166 mhz
// R7 - memory clock codes 000..011 give 33, 40, 50, 66 mhz
// R8 - memory clock 100..110 give 83, 100, 134 mhz; 111 undefined
// R9 - ata strap 0 selects 125 mhz, 1 selects 133 mhz
// R10 - clock codes become 24-bit words shifted to synthesizer before cpu runs
// R11 - config pins driven during reset, released after reset deasserts
`timescale 1ns/1ps
`default_nettype none
`include "brc_consts.svh"

module brc_config_select #(
    parameter int HOLD_CYC = `BRC_HOLD_CYC
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              sys_reset_n_i,
    input  wire brc_pkg::brc_cfg_t cfg_sw_i,
    input  wire brc_pkg::brc_cfg_t cfg_reg_i,
    input  wire logic              cfg_use_reg_i,
    output brc_pkg::brc_pins_t     cfg_pins_o,
    output logic                   cfg_pins_oe_o,
    output logic                   config_drive_window_o,
    output logic                   cpu_reset_n_o,
    output logic                   ata_freq_strap_o,
    output logic [7:0]             sysclk_mhz_o,
    output logic [7:0]             memory_clock_mhz_o,
    output logic [7:0]             ata_mhz_o,
    output logic [3:0]             ddr_ratio_o,
    output logic                   cfg_error_o,
    output logic                   synth_sclk_o,
    output logic                   synth_data_o,
    output logic                   synth_strobe_o
);

    // ======================================================
    // decode helpers
    function automatic logic [7:0] clk_mhz(input logic [2:0] code);
        logic [7:0] f;
        f = `BRC_F_NONE;
        case (code)
            3'h0: f = `BRC_F33;
            3'h1: f = `BRC_F40;
            3'h2: f = `BRC_F50;
            3'h3: f = `BRC_F66;
            3'h4: f = `BRC_F83;
            3'h5: f = `BRC_F100;
            3'h6: f = `BRC_F134;
            default: f = `BRC_F166;
        endcase
        return f;
    endfunction

    brc_pkg::brc_cfg_t   sel;
    brc_pkg::brc_state_t st;
    logic [7:0]          hold_cnt;
    logic                ld_start;
    logic [23:0]         ld_word;
    logic                ld_busy;
    logic                ld_done;
    logic                mem_valid;

    assign sel = cfg_use_reg_i ? cfg_reg_i : cfg_sw_i;

    // ======================================================
    // latch selections and decoded values while reset is held
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_pins_o         <= '{boot_seq: `BRC_BOOT_OFF,
                                    ddr_pll:  `BRC_PLL_6};
            ata_freq_strap_o   <= 1'b0;
            sysclk_mhz_o       <= `BRC_F_NONE;
            memory_clock_mhz_o <= `BRC_F_NONE;
            ata_mhz_o          <= `BRC_F_NONE;
            ddr_ratio_o        <= `BRC_RATIO_NONE;
            cfg_error_o        <= 1'b0;
            mem_valid          <= 1'b0;
        end
        else if (st == brc_pkg::ST_HOLD)
        begin
            // reserved boot code falls back to the safe default
            if (sel.boot_seq == `BRC_BOOT_RSVD)
                cfg_pins_o.boot_seq <= `BRC_BOOT_OFF; // see R3
            else
                cfg_pins_o.boot_seq <= sel.boot_seq; // see R1, see R2
            cfg_pins_o.ddr_pll <= sel.ddr_pll;
            if (sel.ddr_pll == `BRC_PLL_6)
                ddr_ratio_o <= `BRC_RATIO_6; // see R4
            else if (sel.ddr_pll == `BRC_PLL_8)
                ddr_ratio_o <= `BRC_RATIO_8;
            else if (sel.ddr_pll == `BRC_PLL_10)
                ddr_ratio_o <= `BRC_RATIO_10;
            else
                ddr_ratio_o <= `BRC_RATIO_NONE;
            sysclk_mhz_o <= clk_mhz(sel.sysclk_sel); // see R5, see R6
            mem_valid <= sel.memory_clock_freq_sel != `BRC_MEM_UNDEF;
            if (sel.memory_clock_freq_sel == `BRC_MEM_UNDEF)
                memory_clock_mhz_o <= `BRC_F_NONE; // see R8
            else // see R7
                memory_clock_mhz_o <= clk_mhz(sel.memory_clock_freq_sel);
            ata_freq_strap_o <= sel.ata_freq_strap;
            ata_mhz_o <= sel.ata_freq_strap ? `BRC_F133 : `BRC_F125; // see R9
            // judged from the selection itself, not the stale ratio register
            cfg_error_o <= (sel.boot_seq == `BRC_BOOT_RSVD)
                || (sel.ddr_pll < `BRC_PLL_6) || (sel.ddr_pll > `BRC_PLL_10)
                || (sel.memory_clock_freq_sel == `BRC_MEM_UNDEF); // see R4
        end
    end

    // ======================================================
    // reset sequence
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st                    <= brc_pkg::ST_HOLD;
            hold_cnt              <= 8'h00;
            ld_start              <= 1'b0;
            ld_word               <= 24'h000000;
            cfg_pins_oe_o         <= 1'b1;
            config_drive_window_o <= 1'b1;
            cpu_reset_n_o         <= 1'b0;
        end
        else if (!sys_reset_n_i)
        begin
            // any new system reset restarts the sequence from ST_HOLD; a serial load already under way in u_loader runs on to its end
            st                    <= brc_pkg::ST_HOLD;
            ld_start              <= 1'b0;
            cfg_pins_oe_o         <= 1'b1; // see R11
            config_drive_window_o <= 1'b1;
            cpu_reset_n_o         <= 1'b0;
        end
        else
        begin
            ld_start <= 1'b0;
            case (st)
                brc_pkg::ST_HOLD:
                begin
                    st <= brc_pkg::ST_LOAD_SYS;
                end
                brc_pkg::ST_LOAD_SYS:
                begin
                    ld_word  <= 24'(sysclk_mhz_o * `BRC_KHZ_PER_MHZ); // see R10
                    ld_start <= 1'b1;
                    st       <= brc_pkg::ST_WAIT_SYS;
                end
                brc_pkg::ST_WAIT_SYS:
                begin
                    if (ld_done)
                        st <= mem_valid ? brc_pkg::ST_LOAD_MEM
                                        : brc_pkg::ST_DRIVE;
                end
                brc_pkg::ST_LOAD_MEM:
                begin
                    ld_word  <= 24'(memory_clock_mhz_o * `BRC_KHZ_PER_MHZ);
                    ld_start <= 1'b1;
                    st       <= brc_pkg::ST_WAIT_MEM;
                end
                brc_pkg::ST_WAIT_MEM:
                begin
                    if (ld_done)
                        st <= brc_pkg::ST_DRIVE;
                end
                brc_pkg::ST_DRIVE:
                begin
                    // cpu leaves reset only after the sysclk word, and the memory word when mem_valid, are loaded
                    cpu_reset_n_o <= 1'b1; // see R10
                    hold_cnt      <= 8'(HOLD_CYC - 1);
                    st            <= brc_pkg::ST_RUN;
                end
                default:
                begin
                    // pins held past the release for the processor's hold time
                    if (hold_cnt != 8'h00)
                        hold_cnt <= hold_cnt - 8'h01;
                    else
                    begin
                        cfg_pins_oe_o         <= 1'b0; // see R11
                        config_drive_window_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    brc_synth_loader u_loader (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .start_i   (ld_start),
        .word_i    (ld_word),
        .busy_o    (ld_busy),
        .done_o    (ld_done),
        .sclk_o    (synth_sclk_o),
        .data_o    (synth_data_o),
        .strobe_o  (synth_strobe_o)
    );

    // ======================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i || !sys_reset_n_i);

    boot_normal_a: assert property ( // see R1
        st == brc_pkg::ST_HOLD && sel.boot_seq == `BRC_BOOT_NORMAL
        |=> cfg_pins_o.boot_seq == `BRC_BOOT_NORMAL)
        else $error("boot code 01 not passed");
    boot_ext_a: assert property ( // see R2
        st == brc_pkg::ST_HOLD && sel.boot_seq == `BRC_BOOT_EXT
        |=> cfg_pins_o.boot_seq == `BRC_BOOT_EXT)
        else $error("boot code 10 not passed");
    boot_default_a: assert property ( // see R3
        cfg_pins_oe_o |-> cfg_pins_o.boot_seq != `BRC_BOOT_RSVD)
        else $error("reserved boot code driven");
    ddr_ratio_a: assert property ( // see R4
        cfg_pins_o.ddr_pll == `BRC_PLL_8 |-> ddr_ratio_o == `BRC_RATIO_8)
        else $error("ddr ratio mismatch");
    sys_low_a: assert property ( // see R5
        st == brc_pkg::ST_HOLD && sel.sysclk_sel == 3'h3
        |=> sysclk_mhz_o == `BRC_F66)
        else $error("sysclk 011 not 66");
    sys_high_a: assert property ( // see R6
        st == brc_pkg::ST_HOLD && sel.sysclk_sel == 3'h7
        |=> sysclk_mhz_o == `BRC_F166)
        else $error("sysclk 111 not 166");
    mem_low_a: assert property ( // see R7
        st == brc_pkg::ST_HOLD && sel.memory_clock_freq_sel == 3'h0
        |=> memory_clock_mhz_o == `BRC_F33)
        else $error("memclk 000 not 33");
    mem_undef_a: assert property ( // see R8
        st == brc_pkg::ST_HOLD && sel.memory_clock_freq_sel == `BRC_MEM_UNDEF
        |=> cfg_error_o && !mem_valid)
        else $error("memclk 111 not flagged");
    ata_freq_a: assert property ( // see R9
        ata_freq_strap_o |-> ata_mhz_o == `BRC_F133)
        else $error("ata freq mismatch");
    load_first_a: assert property ( // see R10
        $rose(cpu_reset_n_o) |-> !ld_busy && $past(st) == brc_pkg::ST_DRIVE)
        else $error("cpu released before load");
    pin_release_a: assert property ( // see R11
        $fell(cfg_pins_oe_o) |-> cpu_reset_n_o && hold_cnt == 8'h00)
        else $error("pins released early");

    run_c: cover property ($fell(cfg_pins_oe_o));
    skip_mem_c: cover property (st == brc_pkg::ST_WAIT_SYS && ld_done
                                && !mem_valid);
    strobe_c: cover property ($rose(synth_strobe_o));

endmodule
`default_nettype wire

//--- dv/brc_far_model.sv
/*
 * far side model: clock synthesizer serial port and processor pin capture.
 * assumes msb-first load with data steady while the serial clock is high.
 */
`timescale 1ns/1ps
`default_nettype none

module brc_far_model (
    input  wire logic               synth_sclk_i,
    input  wire logic               synth_data_i,
    input  wire logic               synth_strobe_i,
    input  wire logic               cpu_reset_n_i,
    input  wire brc_pkg::brc_pins_t cfg_pins_i,
    input  wire logic               cfg_pins_oe_i
);
    logic [23:0]        shift = 24'h000000;
    logic [23:0]        words [0:63];
    int                 n_words = 0;
    int                 n_viol = 0;
    brc_pkg::brc_pins_t seen_pins;

    // ==========================================================
    // serial load
    always @(posedge synth_sclk_i)
        shift <= {shift[22:0], synth_data_i};
    always @(posedge synth_strobe_i)
    begin
        words[n_words & 63] = shift;
        n_words++;
    end
    // data may only move while the serial clock is low
    always @(synth_data_i)
        if (synth_sclk_i)
            n_viol++;

    // ==========================================================
    // processor samples its pins as it leaves reset; released pins read junk
    always @(posedge cpu_reset_n_i)
        seen_pins = cfg_pins_oe_i ? cfg_pins_i : ~cfg_pins_i;
endmodule

`default_nettype wire

//--- dv/tb_board_reset_config_select.sv
/*
 * testbench for the board reset configuration select block.
 * assumes brc_pkg, brc_config_select and brc_far_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_board_reset_config_select;
    localparam int HOLD = 4;
    logic               clk_sys_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               sys_reset_n_i = 1'b0;
    brc_pkg::brc_cfg_t  cfg_sw_i = '1;
    brc_pkg::brc_cfg_t  cfg_reg_i = '1;
    logic               cfg_use_reg_i = 1'b0;
    brc_pkg::brc_pins_t cfg_pins_o;
    logic               cfg_pins_oe_o, config_drive_window_o, cpu_reset_n_o;
    logic               ata_freq_strap_o, cfg_error_o;
    logic [7:0]         sysclk_mhz_o, memory_clock_mhz_o, ata_mhz_o;
    logic [3:0]         ddr_ratio_o;
    logic               synth_sclk_o, synth_data_o, synth_strobe_o;
    int                 failures = 0;
    int                 n_compared = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    brc_config_select #(.HOLD_CYC(HOLD)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sys_reset_n_i(sys_reset_n_i), .cfg_sw_i(cfg_sw_i),
        .cfg_reg_i(cfg_reg_i), .cfg_use_reg_i(cfg_use_reg_i),
        .cfg_pins_o(cfg_pins_o), .cfg_pins_oe_o(cfg_pins_oe_o),
        .config_drive_window_o(config_drive_window_o),
        .cpu_reset_n_o(cpu_reset_n_o), .ata_freq_strap_o(ata_freq_strap_o),
        .sysclk_mhz_o(sysclk_mhz_o), .memory_clock_mhz_o(memory_clock_mhz_o),
        .ata_mhz_o(ata_mhz_o), .ddr_ratio_o(ddr_ratio_o),
        .cfg_error_o(cfg_error_o), .synth_sclk_o(synth_sclk_o),
        .synth_data_o(synth_data_o), .synth_strobe_o(synth_strobe_o));

    brc_far_model u_far (
        .synth_sclk_i(synth_sclk_o), .synth_data_i(synth_data_o),
        .synth_strobe_i(synth_strobe_o), .cpu_reset_n_i(cpu_reset_n_o),
        .cfg_pins_i(cfg_pins_o), .cfg_pins_oe_i(cfg_pins_oe_o));

    // ==========================================================
    // expectations and comparison
    function automatic logic [7:0] f_mhz(input logic [2:0] c, input bit mem);
        case (c)
            3'h0: f_mhz = 8'h21;
            3'h1: f_mhz = 8'h28;
            3'h2: f_mhz = 8'h32;
            3'h3: f_mhz = 8'h42;
            3'h4: f_mhz = 8'h53;
            3'h5: f_mhz = 8'h64;
            3'h6: f_mhz = 8'h86;
            default: f_mhz = mem ? 8'h00 : 8'ha6;
        endcase
    endfunction

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        n_compared++;
        if (exp !== got)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // one reset cycle with a given selection, judged end to end
    task automatic boot_case(input int i);
        brc_pkg::brc_cfg_t c;
        logic [1:0]        b;
        logic [2:0]        d;
        logic [3:0]        r;
        int                n0;
        int                k;
        c.boot_seq = i[1:0];
        d = 3'(i % 5);
        c.ddr_pll = d;
        c.sysclk_sel = i[2:0];
        c.memory_clock_freq_sel = ~i[2:0];
        c.ata_freq_strap = i[0];
        b = (i[1:0] == 2'h0) ? 2'h3 : i[1:0];
        r = (d == 3'h2) ? 4'h6 : (d == 3'h3) ? 4'h8 : (d == 3'h4) ? 4'ha : 4'h0;
        n0 = u_far.n_words;
        @(posedge clk_sys_i);
        sys_reset_n_i <= 1'b0;
        cfg_use_reg_i <= i[1];
        cfg_reg_i <= i[1] ? c : ~c;
        cfg_sw_i <= i[1] ? ~c : c;
        repeat (4) @(negedge clk_sys_i);
        chk("pins", {b, d}, cfg_pins_o);
        chk("pins oe", 1'b1, cfg_pins_oe_o);
        chk("drive window", 1'b1, config_drive_window_o);
        chk("cpu held", 1'b0, cpu_reset_n_o);
        chk("sysclk mhz", f_mhz(c.sysclk_sel, 0), sysclk_mhz_o);
        chk("mem mhz", f_mhz(~i[2:0], 1), memory_clock_mhz_o);
        chk("ata mhz", i[0] ? 8'h85 : 8'h7d, ata_mhz_o);
        chk("ata strap", i[0], ata_freq_strap_o);
        chk("ddr ratio", r, ddr_ratio_o);
        chk("error", b != i[1:0] || r == 4'h0 || i[2:0] == 3'h0,
            cfg_error_o);
        @(posedge clk_sys_i);
        sys_reset_n_i <= 1'b1;
        k = 0;
        while (cpu_reset_n_o !== 1'b1 && k < 3000)
        begin
            @(negedge clk_sys_i);
            k++;
        end
        chk("cpu release", 1'b1, cpu_reset_n_o);
        chk("word count", (i[2:0] == 3'h0) ? 24'h000001 : 24'h000002,
            24'(u_far.n_words - n0));
        chk("sys word", f_mhz(c.sysclk_sel, 0) * 24'h0003e8,
            u_far.words[n0 & 63]);
        if (i[2:0] != 3'h0)
            chk("mem word", f_mhz(~i[2:0], 1) * 24'h0003e8,
                u_far.words[(n0 + 1) & 63]);
        chk("pins at release", {b, d}, u_far.seen_pins);
        chk("oe after release", 1'b1, cfg_pins_oe_o);
        repeat (HOLD + 2) @(negedge clk_sys_i);
        chk("oe released", 1'b0, cfg_pins_oe_o);
        chk("window closed", 1'b0, config_drive_window_o);
        @(posedge clk_sys_i);
        cfg_sw_i <= ~cfg_sw_i;
        cfg_reg_i <= ~cfg_reg_i;
        repeat (3) @(negedge clk_sys_i);
        chk("sysclk kept", f_mhz(c.sysclk_sel, 0), sysclk_mhz_o);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        repeat (20) @(negedge clk_sys_i);
        chk("boot default", 2'h3, cfg_pins_o.boot_seq);
        chk("oe in reset", 1'b1, cfg_pins_oe_o);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            boot_case(i);
        chk("serial timing", 24'h000000, 24'(u_far.n_viol));
        tally_and_finish();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        failures++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
